// ===== logic/spaa_pkg.sv
// Purpose: constants and carriers for the servo parameter area access block
// Assumes: word-addressed register space, 16-bit words, single clock mclk
// Notes: group size and implemented parameter count are plain defaults
// Functional notes
// - decode persistent, temporary and monitor E000-EFFF word regions; bits 0-F per word
// - persistent register number is parameter number plus base 0000
// - temporary register number is parameter number plus base 1000
// - listed 32-bit registers are accessed as one two-word pair
// - persistent read returns working volatile value, never stored copy
// - persistent write updates working copy and non-volatile copy; next-cycle persistent write drops a pair's high-word strobe
// - temporary region touches only volatile storage, lost at power off
// - run crossing a register group is refused with consistency error 33
// - nonexistent register number refused with access-denied 31
// - monitor registers reflect live internal state
package spaa_pkg;
  localparam logic [15:0] PERSIST_BASE = 16'h0000;
  localparam logic [15:0] TEMP_BASE    = 16'h1000;
  localparam logic [15:0] MON_BASE     = 16'hE000;
  localparam logic [15:0] MON_LAST     = 16'hEFFF;
  localparam logic [3:0]  TOP_PERSIST  = 4'h0;
  localparam logic [3:0]  TOP_TEMP     = 4'h1;
  localparam logic [3:0]  TOP_MON      = 4'hE;
  localparam int          PARAM_AW     = 6;
  localparam int          PARAM_CNT    = 64;
  localparam int          GROUP_SHIFT  = 11;
  localparam int          MON_CNT      = 32;
  localparam logic [7:0]  ERR_NONE     = 8'h00;
  localparam logic [7:0]  ERR_DENIED   = 8'h31;
  localparam logic [7:0]  ERR_CONSIST  = 8'h33;
  localparam logic [15:0] PAIR_LIST [0:10] = '{16'h020A, 16'h020E, 16'h0210, 16'h0212,
    16'h0282, 16'h051B, 16'h0520, 16'h0522, 16'h0524, 16'h0526, 16'h0531};

  typedef enum logic [1:0] {
    RG_PERSIST = 2'b00,
    RG_TEMP    = 2'b01,
    RG_MON     = 2'b10,
    RG_NONE    = 2'b11
  } spaa_region_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } spaa_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [1:0]  count;
    logic [31:0] wdata;
  } spaa_req_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  err;
    logic [31:0] rdata;
  } spaa_rsp_s;

  typedef struct packed {
    logic                write;
    logic [PARAM_AW-1:0] idx;
    logic [15:0]         data;
  } spaa_nv_s;
endpackage

// ===== logic/spaa_decode.sv
// Purpose: classify a register number into region and index
// Assumes: combinational, used by the access checker
// Notes: pairs and group boundary checked by caller
`timescale 1ns/1ps
module spaa_decode (
  input  wire logic [15:0]          addr,
  output spaa_pkg::spaa_region_e    region,
  output logic [spaa_pkg::PARAM_AW-1:0] idx,
  output logic                      exists
);
  logic [11:0] low;
  always_comb begin
    low = addr[11:0];
    idx = low[spaa_pkg::PARAM_AW-1:0];
    if (addr[15:12] == spaa_pkg::TOP_PERSIST) begin
      region = spaa_pkg::RG_PERSIST;
      exists = (low < 12'(spaa_pkg::PARAM_CNT)) || spaa_pkg_hit(addr);
    end else if (addr[15:12] == spaa_pkg::TOP_TEMP) begin
      region = spaa_pkg::RG_TEMP;
      exists = (low < 12'(spaa_pkg::PARAM_CNT)) || spaa_pkg_hit(addr - spaa_pkg::TEMP_BASE);
    end else if (addr[15:12] == spaa_pkg::TOP_MON) begin
      region = spaa_pkg::RG_MON;
      exists = low < 12'(spaa_pkg::MON_CNT);
      idx    = low[spaa_pkg::PARAM_AW-1:0];
    end else begin
      region = spaa_pkg::RG_NONE;
      exists = 1'b0;
    end
  end

  // both words of each listed pair map onto the implemented window by low bits
  function automatic logic spaa_pkg_hit(input logic [15:0] a);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 11; i++) begin
      if (a == spaa_pkg::PAIR_LIST[i] || a == spaa_pkg::PAIR_LIST[i] + 16'h0001) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction
endmodule // spaa_decode

// ===== logic/servo_param_area_access.sv
// Purpose: access checker and storage router for parameter and monitor areas
// Assumes: request arrives as one-cycle pulse, answer after fixed latency
// Notes: non-volatile writes leave as a strobe per word; a persistent write in the next cycle drops a pair's high-word strobe
`timescale 1ns/1ps
module servo_param_area_access (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire spaa_pkg::spaa_req_s        req,
  output spaa_pkg::spaa_rsp_s             rsp,
  output spaa_pkg::spaa_nv_s              nvWrite,
  input  wire logic [spaa_pkg::MON_CNT*16-1:0] monLive
);
  typedef struct packed {
    spaa_pkg::spaa_rsp_s rsp;
    spaa_pkg::spaa_nv_s  nv;
    logic [15:0]         nvHiData;
    logic                nvHiPend;
    logic [spaa_pkg::PARAM_AW-1:0] nvHiIdx;
  } spaa_state_s;

  logic        rstSync1_ff;
  logic        rstSync2_ff;
  logic [15:0] persistRam [0:spaa_pkg::PARAM_CNT-1];
  logic [15:0] tempRam    [0:spaa_pkg::PARAM_CNT-1];
  spaa_state_s st_ff;
  spaa_state_s nxt_st;
  spaa_pkg::spaa_region_e regA;
  spaa_pkg::spaa_region_e regB;
  logic [spaa_pkg::PARAM_AW-1:0] idxA;
  logic [spaa_pkg::PARAM_AW-1:0] idxB;
  logic        exA;
  logic        exB;
  logic [15:0] lastAddr;
  logic        twoWord;
  logic        crossGroup;
  logic        refuse;
  logic        doWrite;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  assign twoWord  = (req.count == 2'd2);
  assign lastAddr = twoWord ? req.addr + 16'h0001 : req.addr;

  spaa_decode u_decA (
    .addr   (req.addr),
    .region (regA),
    .idx    (idxA),
    .exists (exA)
  );

  spaa_decode u_decB (
    .addr   (lastAddr),
    .region (regB),
    .idx    (idxB),
    .exists (exB)
  );

  function automatic logic [15:0] grp(input logic [15:0] a);
    return a >> spaa_pkg::GROUP_SHIFT;
  endfunction

  always_comb begin
    crossGroup = grp(req.addr) != grp(lastAddr);
    refuse     = !exA || !exB || crossGroup || (req.count == 2'd0);
    doWrite    = req.valid && req.write && !refuse && (regA != spaa_pkg::RG_MON);
  end

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp.valid = req.valid;
    nxt_st.nv.write  = 1'b0;
    if (st_ff.nvHiPend) begin
      nxt_st.nv.write = 1'b1;
      nxt_st.nv.idx   = st_ff.nvHiIdx;
      nxt_st.nv.data  = st_ff.nvHiData;
      nxt_st.nvHiPend = 1'b0;
    end
    if (req.valid) begin
      nxt_st.rsp.rdata = '0;
      if (crossGroup) begin
        nxt_st.rsp.err = spaa_pkg::ERR_CONSIST;
      end else if (refuse || (req.write && regA == spaa_pkg::RG_MON)) begin
        nxt_st.rsp.err = spaa_pkg::ERR_DENIED;
      end else begin
        nxt_st.rsp.err = spaa_pkg::ERR_NONE;
        if (!req.write) begin
          if (regA == spaa_pkg::RG_MON) begin
            nxt_st.rsp.rdata[15:0] = monLive[16*idxA +: 16];
            if (twoWord) nxt_st.rsp.rdata[31:16] = monLive[16*idxB +: 16];
          end else if (regA == spaa_pkg::RG_TEMP) begin
            nxt_st.rsp.rdata[15:0] = tempRam[idxA];
            if (twoWord) nxt_st.rsp.rdata[31:16] = tempRam[idxB];
          end else begin
            nxt_st.rsp.rdata[15:0] = persistRam[idxA];
            if (twoWord) nxt_st.rsp.rdata[31:16] = persistRam[idxB];
          end
        end else if (regA == spaa_pkg::RG_PERSIST) begin
          nxt_st.nv.write = 1'b1;
          nxt_st.nv.idx   = idxA;
          nxt_st.nv.data  = req.wdata[15:0];
          nxt_st.nvHiPend = twoWord;
          nxt_st.nvHiIdx  = idxB;
          nxt_st.nvHiData = req.wdata[31:16];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync2_ff) begin
    if (!rstSync2_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // working copies: both words of a pair land in the same cycle
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      if (regA == spaa_pkg::RG_PERSIST) begin
        persistRam[idxA] <= req.wdata[15:0];
        if (twoWord) persistRam[idxB] <= req.wdata[31:16];
      end else begin
        tempRam[idxA] <= req.wdata[15:0];
        if (twoWord) tempRam[idxB] <= req.wdata[31:16];
      end
    end
  end

  assign rsp     = st_ff.rsp;
  assign nvWrite = st_ff.nv;

  a_refuse_code: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && !exA |=> rsp.valid && rsp.err != spaa_pkg::ERR_NONE)
    else $error("missing register not refused");
  a_cross_group: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && crossGroup |=> rsp.err == spaa_pkg::ERR_CONSIST)
    else $error("group crossing not refused");
  a_refuse_nowrite: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && refuse && !st_ff.nvHiPend |=> !nvWrite.write)
    else $error("refused access wrote storage");
  a_persist_nv: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_PERSIST |=> nvWrite.write && nvWrite.data == $past(req.wdata[15:0]))
    else $error("persistent write skipped storage");
  a_temp_volatile: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_TEMP && !st_ff.nvHiPend |=> !nvWrite.write)
    else $error("temporary write reached storage");
  a_pair_high: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_PERSIST && twoWord |=> ##1 nvWrite.write)
    else $error("pair high word not stored");
  a_mon_readonly: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && req.write && regA == spaa_pkg::RG_MON && !crossGroup
    |=> rsp.err == spaa_pkg::ERR_DENIED)
    else $error("monitor write accepted");
  a_answer_once: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid |=> rsp.valid)
    else $error("no answer to request");

  // answer codes and data
  a_count_zero: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && req.count == 2'd0
    |=> rsp.err == spaa_pkg::ERR_DENIED)
    else $error("empty run not refused");
  a_missing_last: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && !exB && !crossGroup
    |=> rsp.err == spaa_pkg::ERR_DENIED)
    else $error("missing second word not refused");
  a_ok_answer: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && !refuse && !(req.write && regA == spaa_pkg::RG_MON)
    |=> rsp.err == spaa_pkg::ERR_NONE)
    else $error("legal access refused");
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    !req.valid
    |=> !rsp.valid)
    else $error("answer without request");
  a_region_none: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && regA == spaa_pkg::RG_NONE
    |=> rsp.err != spaa_pkg::ERR_NONE)
    else $error("unmapped region accepted");
  a_refuse_rdata: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && refuse
    |=> rsp.rdata == '0)
    else $error("refused access returned data");
  a_err_hold: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    !req.valid
    |=> $stable(rsp.err))
    else $error("error code changed without request");

  // storage strobes
  a_read_no_nv: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && !req.write && !st_ff.nvHiPend
    |=> !nvWrite.write)
    else $error("read reached storage");
  a_mon_no_nv: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && regA == spaa_pkg::RG_MON && !st_ff.nvHiPend
    |=> !nvWrite.write)
    else $error("monitor access reached storage");
  a_cross_nowrite: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    req.valid && crossGroup && !st_ff.nvHiPend
    |=> !nvWrite.write)
    else $error("group crossing reached storage");
  a_persist_idx: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_PERSIST
    |=> nvWrite.idx == $past(req.addr[spaa_pkg::PARAM_AW-1:0]))
    else $error("stored index differs from parameter number");
  a_pair_data: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_PERSIST && twoWord
    |=> ##1 nvWrite.data == $past(req.wdata[31:16], 2))
    else $error("pair high word data wrong");
  a_pair_idx: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_PERSIST && twoWord
    |=> ##1 nvWrite.idx == $past(idxB, 2))
    else $error("pair high word index wrong");
  a_temp_no_pend: assert property (@(posedge mclk) disable iff (!rstSync2_ff)
    doWrite && regA == spaa_pkg::RG_TEMP
    |=> !st_ff.nvHiPend)
    else $error("temporary write queued a stored word");
endmodule // servo_param_area_access

// ===== testbench/spaa_master_model.sv
// Purpose: display master stand-in that issues register requests
// Assumes: caller enters just after a rising edge
// Notes: released request fields show inverted values
`timescale 1ns/1ps
module spaa_master_model (
  input  wire logic                mclk,
  output spaa_pkg::spaa_req_s      req,
  input  wire spaa_pkg::spaa_rsp_s rsp
);
  initial req = '0;
  // one request, answer taken while it stands, then one idle cycle
  task automatic access(input logic wr, input logic [15:0] a, input logic [1:0] n,
                        input logic [31:0] wd, output logic [8:0] ans,
                        output logic [31:0] rd);
    req = '{1'b1, wr, a, n, wd};
    @(posedge mclk);
    #1;
    ans = {rsp.valid, rsp.err};
    rd  = rsp.rdata;
    req = '{1'b0, ~wr, ~a, ~n, ~wd};
    @(posedge mclk);
    #1;
  endtask
  // bit set as whole-word read-modify-write
  task automatic set_bit(input logic [15:0] a, input logic [3:0] b, output logic [8:0] ans);
    logic [31:0] rd;
    access(1'b0, a, 2'h1, 32'h0000_0000, ans, rd);
    access(1'b1, a, 2'h1, {16'h0000, rd[15:0] | (16'h0001 << b)}, ans, rd);
  endtask
endmodule // spaa_master_model

// ===== testbench/servo_param_area_access_tb.sv
// Purpose: self-checking bench for the parameter area access block
// Assumes: answer one cycle after a request is taken
// Notes: non-volatile strobes are collected in a queue
`timescale 1ns/1ps
module servo_param_area_access_tb;
  logic                            mclk;
  logic                            rst_n;
  spaa_pkg::spaa_req_s             req;
  spaa_pkg::spaa_rsp_s             rsp;
  spaa_pkg::spaa_nv_s              nvWrite;
  logic [spaa_pkg::MON_CNT*16-1:0] monLive;
  spaa_pkg::spaa_nv_s              nvQ[$];
  logic [8:0]                      ans;
  logic [31:0]                     rd;
  int                              num_errors = 0;
  int                              num_checks = 0;

  servo_param_area_access i_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp),
                                 .nvWrite(nvWrite), .monLive(monLive));
  spaa_master_model i_master (.mclk(mclk), .req(req), .rsp(rsp));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (nvWrite.write === 1'b1) nvQ.push_back(nvWrite);
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [1:0] n,
                     input logic [31:0] wd);
    i_master.access(wr, a, n, wd, ans, rd);
  endtask

  task automatic t_persist();
    nvQ.delete();
    acc(1'b1, 16'h0001, 2'h1, 32'h0000_1234);
    check("write answer", 32'h0000_0100, ans);
    acc(1'b0, 16'h0001, 2'h1, 32'h0000_0000);
    check("read word", 32'h0000_1234, rd[15:0]);
    check("nv count", 32'h0000_0001, nvQ.size());
    check("nv strobe", 32'h0001_1234, {nvQ[0].idx, nvQ[0].data});
    $display("test persist done");
  endtask
  task automatic t_temp();
    nvQ.delete();
    acc(1'b1, 16'h1001, 2'h1, 32'h0000_BEEF);
    acc(1'b0, 16'h1001, 2'h1, 32'h0000_0000);
    check("temp read", 32'h0000_BEEF, rd[15:0]);
    acc(1'b0, 16'h0001, 2'h1, 32'h0000_0000);
    check("persist kept", 32'h0000_1234, rd[15:0]);
    check("nv count", 32'h0000_0000, nvQ.size());
    $display("test temp done");
  endtask
  task automatic t_pair();
    nvQ.delete();
    acc(1'b1, 16'h020A, 2'h2, 32'hCAFE_F00D);
    acc(1'b0, 16'h020A, 2'h2, 32'h0000_0000);
    check("pair read", 32'hCAFE_F00D, rd);
    check("nv count", 32'h0000_0002, nvQ.size());
    check("nv low", 32'h000A_F00D, {nvQ[0].idx, nvQ[0].data});
    check("nv high", 32'h000B_CAFE, {nvQ[1].idx, nvQ[1].data});
    acc(1'b1, 16'h120A, 2'h2, 32'h1357_2468);
    check("temp pair answer", 32'h0000_0100, ans);
    acc(1'b0, 16'h120A, 2'h2, 32'h0000_0000);
    check("temp pair read", 32'h1357_2468, rd);
    acc(1'b0, 16'h020A, 2'h2, 32'h0000_0000);
    check("pair kept", 32'hCAFE_F00D, rd);
    check("nv count after temp", 32'h0000_0002, nvQ.size());
    $display("test pair done");
  endtask
  task automatic t_refuse();
    logic [15:0] ra[6] = '{16'h003F, 16'h0100, 16'hE000, 16'h0001, 16'h1100, 16'h2000};
    logic [1:0]  rn[6] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1};
    acc(1'b1, 16'h003F, 2'h1, 32'h0000_5A5A);
    nvQ.delete();
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, ra[i], rn[i], 32'hFFFF_FFFF);
      check("denied", 32'h0000_0131, ans);
    end
    acc(1'b1, 16'h07FF, 2'h2, 32'hFFFF_FFFF);
    check("crossing", 32'h0000_0001, 32'(ans == 9'h133 || ans == 9'h131));
    acc(1'b0, 16'h003F, 2'h1, 32'h0000_0000);
    check("kept 003F", 32'h0000_5A5A, rd[15:0]);
    acc(1'b0, 16'h0001, 2'h1, 32'h0000_0000);
    check("kept 0001", 32'h0000_1234, rd[15:0]);
    check("nv count", 32'h0000_0000, nvQ.size());
    $display("test refuse done");
  endtask
  task automatic t_monitor();
    acc(1'b0, 16'hE003, 2'h2, 32'h0000_0000);
    check("mon pair", 32'hA004_A003, rd);
    monLive[15:0] = 16'h5555;
    acc(1'b0, 16'hE000, 2'h1, 32'h0000_0000);
    check("mon live", 32'h0000_5555, rd[15:0]);
    i_master.set_bit(16'h1001, 4'h4, ans);
    acc(1'b0, 16'h1001, 2'h1, 32'h0000_0000);
    check("bit set", 32'h0000_BEFF, rd[15:0]);
    $display("test monitor and bit done");
  endtask

  initial begin
    rst_n = 1'b0;
    for (int i = 0; i < spaa_pkg::MON_CNT; i++) monLive[16*i +: 16] = 16'hA000 + 16'(i);
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    t_persist();
    t_temp();
    t_pair();
    t_refuse();
    t_monitor();
    summarize();
  end
  initial begin
    #(2000 * 50);
    num_errors++;
    summarize();
  end
endmodule // servo_param_area_access_tb
